// ==== core/btc_pkg.sv ====
// Package with register map, field layouts and operation codes of the bit/signed_bound_op/compare unit.
package btc_pkg;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_DEST = 8'h04;
   localparam logic [7:0] ADDR_SRC = 8'h08;
   localparam logic [7:0] ADDR_LIMIT = 8'h0c;
   localparam logic [7:0] ADDR_BITNUM = 8'h10;
   localparam logic [7:0] ADDR_BASE = 8'h14;
   localparam logic [7:0] ADDR_FLAGS = 8'h18;
   localparam logic [7:0] ADDR_RESULT = 8'h1c;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   localparam logic [7:0] ADDR_BITADDR = 8'h24;

   // ----------------------------------------------------------------
   // Flag register bit positions and reset values
   // ----------------------------------------------------------------
   localparam int FLG_C = 0;
   localparam int FLG_D = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_S = 3;
   localparam int FLG_B = 4;
   localparam int FLG_O = 5;
   localparam int FLG_I = 6;
   localparam int FLG_U = 7;
   localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [31:0] FLAGS_USED = 32'h0000_00ff;

   // ----------------------------------------------------------------
   // Status register bit positions and operand widths
   // ----------------------------------------------------------------
   localparam int ST_WB = 0;
   localparam int ST_DONE = 1;
   localparam int ST_ILLEGAL = 2;
   localparam int SHORT_BASE_W = 19;
   localparam int LONG_BASE_W = 27;
   localparam logic [31:0] AREG_MASK = 32'h00ff_ffff;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Operation, size and operand encodings
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_BIT_TEST = 3'h0,
      OP_BIT_TEST_CLEAR = 3'h1,
      OP_BIT_XOR_CARRY = 3'h2,
      OP_BIT_TEST_SET = 3'h3,
      OP_SIGNED_BOUND = 3'h6,
      OP_COMPARE = 3'h7
   } btc_op_e;

   typedef enum logic [1:0] {
      SZ_BYTE = 2'h0,
      SZ_WORD = 2'h1,
      SZ_LONG = 2'h2
   } btc_size_e;

   typedef enum logic [1:0] {
      BK_DATA_HALF = 2'h0,
      BK_ADDR_REG = 2'h1,
      BK_MEMORY = 2'h2
   } btc_bitk_e;

   typedef struct packed {
      logic [18:0] rsvd;
      logic indirect;
      logic src_imm;
      logic short_fmt;
      logic quick_fmt;
      logic src_areg;
      logic dest_areg;
      btc_bitk_e bitk;
      btc_size_e size;
      btc_op_e op;
   } btc_cmd_s;

endpackage : btc_pkg

// ==== core/btc_unit.sv ====
// Bit test, bit exclusive-OR, signed signed_bound_op and compare datapath behind an AXI4-Lite slave.

// Summary of operation
// - Bit test: Z gets inverted bit, C bit.
// - Test-and-clear sets flags, then writes 0.
// - Test-and-set sets flags, then writes 1.
// - Address register bit operand: low 8 bits only.
// - Bit xor: C becomes C xor bit.
// - Signed_bound_op bounds dest signed, flags unchanged.
// - Word signed_bound_op to address register zeroes top 8.
// - Compare subtracts, sets flags, writes nothing.
// - Byte compare, address dest: 16-bit zero-extended source.
// - Long compare zero-extends address registers to 32.
// - Overflow set on signed range overflow.
// - Sign flag equals difference MSB.
// - Zero flag set when difference is zero.
// - Carry set when no borrow.
// - Indirect operands allowed except immediates.
module btc_unit (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic [31:0] flags_o,
   output logic [31:0] result_o,
   output logic wb_valid_o
);
   import btc_pkg::*;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : apply_strb

   function automatic logic [4:0] size_msb(input btc_size_e sz, input logic dest_areg);
      case (sz)
         SZ_BYTE: size_msb = dest_areg ? 5'd15 : 5'd7;
         SZ_WORD: size_msb = 5'd15;
         default: size_msb = 5'd31;
      endcase
   endfunction : size_msb

   function automatic logic signed [31:0] sext(input logic [31:0] v, input btc_size_e sz);
      sext = (sz == SZ_BYTE) ? {{24{v[7]}}, v[7:0]} : {{16{v[15]}}, v[15:0]};
   endfunction : sext

   // ----------------------------------------------------------------
   // Register file and bus state
   // ----------------------------------------------------------------
   btc_cmd_s cmd_reg;
   logic [31:0] dest_reg, src_reg, limit_reg, bitnum_reg, base_reg;
   logic [31:0] flags_reg, result_reg, bit_addr_reg;
   logic wb_valid_reg, done_reg, illegal_reg, exec_reg;
   logic aw_held_reg, w_held_reg, awready_reg, wready_reg, bvalid_reg;
   logic arready_reg, rvalid_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg, rdata_reg;
   logic [3:0] w_strb_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic do_write;

   assign s_axi_awready_o = awready_reg;
   assign s_axi_wready_o = wready_reg;
   assign s_axi_bvalid_o = bvalid_reg;
   assign s_axi_bresp_o = bresp_reg;
   assign s_axi_arready_o = arready_reg;
   assign s_axi_rvalid_o = rvalid_reg;
   assign s_axi_rdata_o = rdata_reg;
   assign s_axi_rresp_o = rresp_reg;
   assign flags_o = flags_reg;
   assign result_o = result_reg;
   assign wb_valid_o = wb_valid_reg;
   assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   // Address and data are caught independently, so either may come first.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         aw_addr_reg <= 8'h00;
         w_data_reg <= WORD_RST;
         w_strb_reg <= 4'h0;
      end else begin
         if (s_axi_awvalid_i && awready_reg) begin
            aw_addr_reg <= s_axi_awaddr_i;
            aw_held_reg <= 1'b1;
            awready_reg <= 1'b0;
         end
         if (s_axi_wvalid_i && wready_reg) begin
            w_data_reg <= s_axi_wdata_i;
            w_strb_reg <= s_axi_wstrb_i;
            w_held_reg <= 1'b1;
            wready_reg <= 1'b0;
         end
         if (do_write) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            case (aw_addr_reg)
               ADDR_CMD, ADDR_DEST, ADDR_SRC, ADDR_LIMIT,
               ADDR_BITNUM, ADDR_BASE, ADDR_FLAGS: bresp_reg <= RESP_OKAY;
               default: bresp_reg <= RESP_SLVERR;
            endcase
         end
         if (bvalid_reg && s_axi_bready_i) begin
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         cmd_reg <= btc_cmd_s'(WORD_RST);
         dest_reg <= WORD_RST;
         src_reg <= WORD_RST;
         limit_reg <= WORD_RST;
         bitnum_reg <= WORD_RST;
         base_reg <= WORD_RST;
         exec_reg <= 1'b0;
      end else begin
         exec_reg <= do_write && (aw_addr_reg == ADDR_CMD);
         if (do_write) begin
            case (aw_addr_reg)
               ADDR_CMD: cmd_reg <= btc_cmd_s'(apply_strb(cmd_reg, w_data_reg, w_strb_reg));
               ADDR_DEST: dest_reg <= apply_strb(dest_reg, w_data_reg, w_strb_reg);
               ADDR_SRC: src_reg <= apply_strb(src_reg, w_data_reg, w_strb_reg);
               ADDR_LIMIT: limit_reg <= apply_strb(limit_reg, w_data_reg, w_strb_reg);
               ADDR_BITNUM: bitnum_reg <= apply_strb(bitnum_reg, w_data_reg, w_strb_reg);
               ADDR_BASE: base_reg <= apply_strb(base_reg, w_data_reg, w_strb_reg);
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= WORD_RST;
         rresp_reg <= RESP_OKAY;
      end else begin
         if (s_axi_arvalid_i && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rresp_reg <= RESP_OKAY;
            case (s_axi_araddr_i)
               ADDR_CMD: rdata_reg <= cmd_reg;
               ADDR_DEST: rdata_reg <= dest_reg;
               ADDR_SRC: rdata_reg <= src_reg;
               ADDR_LIMIT: rdata_reg <= limit_reg;
               ADDR_BITNUM: rdata_reg <= bitnum_reg;
               ADDR_BASE: rdata_reg <= base_reg;
               ADDR_FLAGS: rdata_reg <= flags_reg;
               ADDR_RESULT: rdata_reg <= result_reg;
               ADDR_STATUS: rdata_reg <= {29'h0, illegal_reg, done_reg, wb_valid_reg};
               ADDR_BITADDR: rdata_reg <= bit_addr_reg;
               default: begin
                  rdata_reg <= WORD_RST;
                  rresp_reg <= RESP_SLVERR;
               end
            endcase
         end
         if (rvalid_reg && s_axi_rready_i) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Bit operand selection
   // ----------------------------------------------------------------
   // All bit operands arrive as one byte in the destination word; an address
   // register therefore never exposes more than its low byte.
   logic [2:0] bit_idx;
   logic sel_bit;
   logic [26:0] base_eff;
   logic [26:0] bit_addr_next;
   assign bit_idx = bitnum_reg[2:0];
   assign sel_bit = dest_reg[bit_idx];
   assign base_eff = cmd_reg.short_fmt ? {8'h00, base_reg[SHORT_BASE_W-1:0]}
                                       : base_reg[LONG_BASE_W-1:0];
   assign bit_addr_next = base_eff + {3'b000, bitnum_reg[26:3]};

   // ----------------------------------------------------------------
   // Compare arithmetic
   // ----------------------------------------------------------------
   logic [4:0] cmp_msb;
   logic [31:0] cmp_mask, cmp_a, cmp_b, cmp_b_raw, cmp_diff;
   logic [32:0] cmp_sub;
   logic cmp_c, cmp_z, cmp_s, cmp_o;

   always_comb begin
      cmp_msb = size_msb(cmd_reg.size, cmd_reg.dest_areg);
      cmp_mask = 32'hffff_ffff >> (5'd31 - cmp_msb);
      cmp_b_raw = cmd_reg.quick_fmt ? {{28{src_reg[3]}}, src_reg[3:0]} : src_reg;
      if (cmd_reg.size == SZ_BYTE) begin
         cmp_b = {24'h0, cmp_b_raw[7:0]};
      end else if (cmd_reg.size == SZ_LONG && cmd_reg.src_areg) begin
         cmp_b = cmp_b_raw & AREG_MASK;
      end else begin
         cmp_b = cmp_b_raw & cmp_mask;
      end
      if (cmd_reg.size == SZ_LONG && cmd_reg.dest_areg) begin
         cmp_a = dest_reg & AREG_MASK;
      end else begin
         cmp_a = dest_reg & cmp_mask;
      end
      cmp_sub = {1'b0, cmp_a} - {1'b0, cmp_b};
      cmp_diff = cmp_sub[31:0] & cmp_mask;
      cmp_c = !cmp_sub[32];
      cmp_z = (cmp_diff == 32'h0);
      cmp_s = cmp_diff[cmp_msb];
      cmp_o = (cmp_a[cmp_msb] ^ cmp_b[cmp_msb]) & (cmp_a[cmp_msb] ^ cmp_diff[cmp_msb]);
   end

   // ----------------------------------------------------------------
   // Signed_bound_op arithmetic
   // ----------------------------------------------------------------
   logic signed [31:0] signed_bound_op_d, signed_bound_op_lo, signed_bound_op_hi, signed_bound_op_t1, signed_bound_op_t2;
   logic [31:0] signed_bound_op_res;

   always_comb begin
      signed_bound_op_d = sext(dest_reg, cmd_reg.size);
      signed_bound_op_lo = sext(src_reg, cmd_reg.size);
      signed_bound_op_hi = sext(limit_reg, cmd_reg.size);
      signed_bound_op_t1 = (signed_bound_op_lo > signed_bound_op_d) ? signed_bound_op_lo : signed_bound_op_d;
      signed_bound_op_t2 = (signed_bound_op_hi < signed_bound_op_t1) ? signed_bound_op_hi : signed_bound_op_t1;
      if (cmd_reg.size == SZ_BYTE) begin
         signed_bound_op_res = {dest_reg[31:8], signed_bound_op_t2[7:0]};
      end else if (cmd_reg.dest_areg) begin
         signed_bound_op_res = {16'h0, signed_bound_op_t2[15:0]};
      end else begin
         signed_bound_op_res = {dest_reg[31:16], signed_bound_op_t2[15:0]};
      end
   end

   // ----------------------------------------------------------------
   // Execution and result registers
   // ----------------------------------------------------------------
   // Illegal combinations are still executed; the status bit only warns software.
   logic illegal_next;
   assign illegal_next = (cmd_reg.op == OP_COMPARE && cmd_reg.size == SZ_BYTE &&
                          cmd_reg.src_areg && cmd_reg.dest_areg) ||
                         (cmd_reg.op == OP_SIGNED_BOUND && !(signed_bound_op_lo < signed_bound_op_hi)) ||
                         (cmd_reg.indirect && cmd_reg.src_imm);

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         flags_reg <= FLAGS_RST;
         result_reg <= WORD_RST;
         wb_valid_reg <= 1'b0;
         done_reg <= 1'b0;
         illegal_reg <= 1'b0;
         bit_addr_reg <= WORD_RST;
      end else if (exec_reg) begin
         done_reg <= 1'b1;
         illegal_reg <= illegal_next;
         bit_addr_reg <= (cmd_reg.bitk == BK_MEMORY) ? {5'h00, bit_addr_next} : WORD_RST;
         result_reg <= dest_reg;
         wb_valid_reg <= 1'b0;
         case (cmd_reg.op)
            OP_BIT_TEST, OP_BIT_TEST_CLEAR, OP_BIT_TEST_SET: begin
               flags_reg[FLG_Z] <= !sel_bit;
               flags_reg[FLG_C] <= sel_bit;
               if (cmd_reg.op != OP_BIT_TEST) begin
                  result_reg[bit_idx] <= (cmd_reg.op == OP_BIT_TEST_SET);
                  wb_valid_reg <= 1'b1;
               end
            end
            OP_BIT_XOR_CARRY: begin
               flags_reg[FLG_C] <= flags_reg[FLG_C] ^ sel_bit;
            end
            OP_SIGNED_BOUND: begin
               result_reg <= signed_bound_op_res;
               wb_valid_reg <= (signed_bound_op_t2 != signed_bound_op_d) || (cmd_reg.size == SZ_WORD &&
                               cmd_reg.dest_areg && dest_reg[31:16] != 16'h0);
            end
            OP_COMPARE: begin
               flags_reg[FLG_O] <= cmp_o;
               flags_reg[FLG_S] <= cmp_s;
               flags_reg[FLG_Z] <= cmp_z;
               flags_reg[FLG_C] <= cmp_c;
            end
            default: ;
         endcase
      end else if (do_write && aw_addr_reg == ADDR_FLAGS) begin
         flags_reg <= apply_strb(flags_reg, w_data_reg, w_strb_reg) & FLAGS_USED;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   bit_test_flags_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      exec_reg && (cmd_reg.op == OP_BIT_TEST) |=>
      flags_reg[FLG_C] == $past(sel_bit) && flags_reg[FLG_Z] == !$past(sel_bit))
      else $error("bit test flags wrong");

   bit_other_flags_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      exec_reg && cmd_reg.op != OP_COMPARE |=>
      flags_reg[FLG_O] == $past(flags_reg[FLG_O]) && flags_reg[FLG_S] == $past(flags_reg[FLG_S]))
      else $error("untouched flag changed");

   test_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      exec_reg && (cmd_reg.op == OP_BIT_TEST_CLEAR) |=>
      !result_reg[$past(bit_idx)] && wb_valid_reg && flags_reg[FLG_C] == $past(sel_bit))
      else $error("test and clear wrong");

   test_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      exec_reg && (cmd_reg.op == OP_BIT_TEST_SET) |=>
      result_reg[$past(bit_idx)] && wb_valid_reg && flags_reg[FLG_Z] == !$past(sel_bit))
      else $error("test and set wrong");

   areg_low_byte_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      exec_reg && cmd_reg.bitk == BK_ADDR_REG && cmd_reg.op == OP_BIT_TEST_SET |=>
      result_reg[31:8] == $past(dest_reg[31:8]))
      else $error("bit op touched high address bits");

   xor_carry_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      exec_reg && (cmd_reg.op == OP_BIT_XOR_CARRY) |=>
      flags_reg[FLG_C] == ($past(flags_reg[FLG_C]) ^ $past(sel_bit)) &&
      flags_reg[FLG_Z] == $past(flags_reg[FLG_Z]))
      else $error("xor carry wrong");

   signed_bound_op_flags_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      exec_reg && (cmd_reg.op == OP_SIGNED_BOUND) |=> $stable(flags_reg))
      else $error("signed_bound_op altered flags");

   signed_bound_op_areg_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      exec_reg && cmd_reg.op == OP_SIGNED_BOUND && cmd_reg.size == SZ_WORD &&
      cmd_reg.dest_areg |=> !wb_valid_reg || result_reg[23:16] == 8'h00)
      else $error("signed_bound_op high bits not cleared");

   cmp_no_write_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      exec_reg && (cmd_reg.op == OP_COMPARE) |=> !wb_valid_reg ##1 done_reg)
      else $error("compare wrote back");

   cmp_zero_carry_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      exec_reg && (cmd_reg.op == OP_COMPARE) |=>
      flags_reg[FLG_Z] == ($past(cmp_a) == $past(cmp_b)) &&
      flags_reg[FLG_C] == ($past(cmp_a) >= $past(cmp_b)))
      else $error("compare zero or carry wrong");

endmodule : btc_unit

// ==== tb/btc_host_model.sv ====
// Register bus master that stands in for the CPU side of the unit.
module btc_host_model (
   input wire logic clk_i,
   output logic [7:0] awa_o,
   output logic awv_o,
   input wire logic awr_i,
   output logic [31:0] wd_o,
   output logic [3:0] ws_o,
   output logic wv_o,
   input wire logic wr_i,
   input wire logic [1:0] br_i,
   input wire logic bv_i,
   output logic bry_o,
   output logic [7:0] ara_o,
   output logic arv_o,
   input wire logic arr_i,
   input wire logic [31:0] rd_i,
   input wire logic [1:0] rr_i,
   input wire logic rv_i,
   output logic rry_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {awa_o, awv_o, wd_o, ws_o, wv_o, bry_o, ara_o, arv_o, rry_o} = '0;
   end
   // Released lines show the inverse so that a late capture cannot pass by luck.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      awa_o <= a;
      awv_o <= 1'b1;
      wd_o <= d;
      ws_o <= 4'hf;
      wv_o <= 1'b1;
      bry_o <= 1'b1;
      forever begin
         @(posedge clk_i);
         if (awv_o && awr_i) begin
            awv_o <= 1'b0;
            awa_o <= ~a;
         end
         if (wv_o && wr_i) begin
            wv_o <= 1'b0;
            wd_o <= ~d;
         end
         if (bv_i) begin
            r = br_i;
            bry_o <= 1'b0;
            break;
         end
      end
      @(posedge clk_i);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      ara_o <= a;
      arv_o <= 1'b1;
      rry_o <= 1'b1;
      forever begin
         @(posedge clk_i);
         if (arv_o && arr_i) begin
            arv_o <= 1'b0;
            ara_o <= ~a;
         end
         if (rv_i) begin
            d = rd_i;
            r = rr_i;
            rry_o <= 1'b0;
            break;
         end
      end
   endtask : rd
endmodule : btc_host_model

// ==== tb/bit_test_signed_bound_op_compare_unit_tb.sv ====
// Self-checking bench for the bit test, signed_bound_op and compare unit.
module bit_test_signed_bound_op_compare_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import btc_pkg::*;
   logic clk, rst_b, awv, awr, wv, wr, bv, bry, arv, arr, rv, rry, wbv;
   logic [7:0] awa, ara;
   logic [31:0] wd, rdat, flags, res, got, pf, ef, dv;
   logic [3:0] ws;
   logic [1:0] br, rr, resp;
   int error_cnt = 0;
   int n_checks = 0;
   int cyc = 0;
   btc_op_e bops[3] = '{OP_BIT_TEST, OP_BIT_TEST_CLEAR, OP_BIT_TEST_SET};
   btc_size_e csz[7] = '{SZ_BYTE, SZ_WORD, SZ_LONG, SZ_LONG, SZ_BYTE, SZ_BYTE, SZ_LONG};
   logic [6:0] cda = 7'b1010000;
   logic [6:0] csa = 7'b0100000;
   logic [31:0] cdv[7] = '{32'h80, 32'h0, 32'h7fffffff, 32'h5, 32'h100, 32'h5, 32'hff000001};
   logic [31:0] csv[7] = '{32'h1, 32'h1, 32'hffffffff, 32'h5, 32'h1, 32'hff05, 32'h1};
   int cw[7] = '{8, 16, 32, 32, 16, 8, 32};
   logic [31:0] cd[3] = '{32'hfb, 32'h14, 32'h04};
   logic [31:0] ce[3] = '{32'hfd, 32'h0a, 32'h04};
   btc_unit btc_unit_i (.clk_i(clk), .rst_b_i(rst_b), .s_axi_awaddr_i(awa),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
      .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
      .s_axi_rready_i(rry), .flags_o(flags), .result_o(res), .wb_valid_o(wbv));
   btc_host_model btc_host_model_i (.clk_i(clk), .awa_o(awa), .awv_o(awv), .awr_i(awr),
      .wd_o(wd), .ws_o(ws), .wv_o(wv), .wr_i(wr), .br_i(br), .bv_i(bv), .bry_o(bry),
      .ara_o(ara), .arv_o(arv), .arr_i(arr), .rd_i(rdat), .rr_i(rr), .rv_i(rv), .rry_o(rry));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic final_report();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         $display("BAD t=%0t run did not finish", $time);
         final_report();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD t=%0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   function automatic logic [31:0] mk(input btc_op_e o, input btc_size_e z,
      input btc_bitk_e k, input logic da, input logic sa);
      return {23'h0, sa, da, k, z, o};
   endfunction : mk
   // Flags expected from a subtraction of s from d at width w.
   function automatic logic [31:0] cmpf(input int w, input logic [31:0] d, s, p);
      logic [32:0] m;
      logic [31:0] a, b, x;
      m = (33'h1 << w) - 33'h1;
      a = d & m[31:0];
      b = s & m[31:0];
      x = (a - b) & m[31:0];
      cmpf = p;
      cmpf[FLG_S] = x[w-1];
      cmpf[FLG_Z] = (x == 32'h0);
      cmpf[FLG_C] = (a >= b);
      cmpf[FLG_O] = (a[w-1] != b[w-1]) && (x[w-1] != a[w-1]);
   endfunction : cmpf
   task automatic go(input logic [31:0] c, d, s, l, b, f);
      btc_host_model_i.wr(ADDR_DEST, d, resp);
      btc_host_model_i.wr(ADDR_SRC, s, resp);
      btc_host_model_i.wr(ADDR_LIMIT, l, resp);
      btc_host_model_i.wr(ADDR_BITNUM, b, resp);
      btc_host_model_i.wr(ADDR_FLAGS, f, resp);
      btc_host_model_i.wr(ADDR_CMD, c, resp);
   endtask : go
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst_b = 1'b0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk(flags, FLAGS_RST);
      // Data half operands only, never the special function area.
      for (int k = 0; k < 6; k++) begin
         pf = 32'hf0 | (k[0] ? 32'h4 : 32'h1);
         go(mk(bops[k/2], SZ_BYTE, BK_DATA_HALF, 1'b0, 1'b0), 32'h5a, 0, 0, k[0] ? 1 : 2, pf);
         chk(flags, (pf & ~32'h5) | (k[0] ? 32'h1 : 32'h4));
         chk(32'(wbv), 32'(k > 1));
         if (k / 2 == 1) chk(res, k[0] ? 32'h58 : 32'h5a);
         if (k / 2 == 2) chk(res, k[0] ? 32'h5a : 32'h5e);
      end
      go(mk(OP_BIT_TEST_SET, SZ_BYTE, BK_ADDR_REG, 1'b0, 1'b0), 32'hffffff00, 0, 0, 32'h8, 0);
      chk(flags, 32'h4);
      chk(res, 32'hffffff01);
      // The short form keeps only the low 19 base bits, so both runs land on one byte.
      for (int k = 0; k < 2; k++) begin
         btc_host_model_i.wr(ADDR_BASE, k ? 32'h80100 : 32'h100, resp);
         go(mk(OP_BIT_TEST, SZ_BYTE, BK_MEMORY, 1'b0, 1'b0) | (k ? 32'h400 : 32'h0),
            32'h20, 0, 0, 32'h2d, 0);
         chk(flags, 32'h1);
         btc_host_model_i.rd(ADDR_BITADDR, got, resp);
         chk(got, 32'h105);
      end
      for (int k = 0; k < 2; k++) begin
         go(mk(OP_BIT_XOR_CARRY, SZ_BYTE, BK_DATA_HALF, 1'b0, 1'b0), 32'h5a, 0, 0, 1, 32'hf0 | k);
         chk(flags, 32'hf0 | 32'(k ^ 1));
      end
      // Lower limit always below the upper one.
      for (int k = 0; k < 3; k++) begin
         go(mk(OP_SIGNED_BOUND, SZ_BYTE, BK_DATA_HALF, 1'b0, 1'b0), cd[k], 32'hfd, 32'h0a, 0, 32'h5a);
         if (k == 2) chk(32'(wbv), 32'h0);
         else chk(32'(res[7:0]), ce[k]);
         chk(flags, 32'h5a);
      end
      go(mk(OP_SIGNED_BOUND, SZ_WORD, BK_DATA_HALF, 1'b1, 1'b0), 32'hab0005, 32'h10, 32'h100, 0, 0);
      chk(32'(res[23:0]), 32'h10);
      chk(32'(wbv), 32'h1);
      // Byte compares never name address registers on both sides.
      for (int k = 0; k < 7; k++) begin
         go(mk(OP_COMPARE, csz[k], BK_DATA_HALF, cda[k], csa[k]), cdv[k], csv[k], 0, 0, 32'h42);
         dv = (csz[k] == SZ_LONG && cda[k]) ? (cdv[k] & AREG_MASK) : cdv[k];
         ef = cmpf(cw[k], dv, csv[k], 32'h42);
         chk(flags, ef);
         chk(32'(wbv), 32'h0);
         btc_host_model_i.rd(ADDR_FLAGS, got, resp);
         chk(got, ef);
      end
      for (int k = 0; k < 2; k++) begin
         go(mk(OP_COMPARE, SZ_WORD, BK_DATA_HALF, 1'b0, 1'b0) | (k ? 32'h1a00 : 32'h1200),
            9, 32'hd, 0, 0, 0);
         chk(flags, cmpf(16, 32'h9, 32'hfffd, 32'h0));
         btc_host_model_i.rd(ADDR_STATUS, got, resp);
         chk(32'(got[ST_ILLEGAL]), 32'(k));
      end
      btc_host_model_i.wr(ADDR_RESULT, 32'h1, resp);
      chk(32'(resp), 32'(RESP_SLVERR));
      btc_host_model_i.rd(8'h3c, got, resp);
      chk(got, 32'h0);
      chk(32'(resp), 32'(RESP_SLVERR));
      final_report();
   end
endmodule : bit_test_signed_bound_op_compare_unit_tb
